// File: hw/cnc_plc_pkg.sv
package cnc_plc_pkg;
  // =========================================================
  // register map: printed offsets are indices, byte = 4 * index
  localparam int unsigned ADDR_W                 = 12;
  localparam logic [9:0]  IDX_KEY_INHIBIT_A      = 10'h1F4;
  localparam logic [9:0]  IDX_KEY_INHIBIT_B      = 10'h1F5;
  localparam logic [9:0]  IDX_KEY_INHIBIT_C      = 10'h1F6;
  localparam logic [9:0]  IDX_SELECTOR_INHIBIT   = 10'h1F7;
  localparam logic [9:0]  IDX_CONV_KEY_INHIBIT   = 10'h1FC;
  localparam logic [9:0]  IDX_ACK_HOLD           = 10'h200;
  localparam logic [9:0]  IDX_STATUS             = 10'h201;
  localparam logic [1:0]  BYTE_LANE_BITS         = 2'h0;
  localparam int unsigned NUM_MASKS              = 5;
  localparam int unsigned SEL_MASK               = 3;
  localparam logic [31:0] MASK_RESET             = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ          = 32'h0000_0000;
  // =========================================================
  // override selector: positions 0..14 sit at mask bits 8..22
  localparam int unsigned OVR_FIRST_BIT          = 8;
  localparam int unsigned OVR_POSITIONS          = 15;
  localparam logic [3:0]  OVR_LOWEST             = 4'h0;
  // =========================================================
  // timing
  localparam int unsigned CLK_HZ                 = 25_000_000;
  localparam int unsigned MIN_ACK_HOLD_NS        = 1000;
  localparam int unsigned HOLD_CYCLES_RAW        =
    (MIN_ACK_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [15:0] ACK_HOLD_RESET         =
    16'((HOLD_CYCLES_RAW < 1) ? 1 : HOLD_CYCLES_RAW);
  // =========================================================
  // status bit positions
  localparam int unsigned ST_STROBE              = 0;
  localparam int unsigned ST_READY               = 1;
  localparam int unsigned ST_START_REQ           = 2;
  localparam int unsigned ST_FEED_HELD           = 3;
  localparam int unsigned ST_ABORT_PEND          = 4;
  // =========================================================
  typedef enum logic [2:0] {
    BK_MOTION     = 3'h0,
    BK_DWELL      = 3'h1,
    BK_MOTIONLESS = 3'h2,
    BK_THREAD     = 3'h3,
    BK_TAP        = 3'h4,
    BK_SPINDLE    = 3'h5
  } block_kind_type;

  typedef enum logic [2:0] {
    AUX_IDLE = 3'b001,
    AUX_LOW  = 3'b010,
    AUX_HIGH = 3'b100
  } aux_state_type;

  typedef enum logic [2:0] {
    AB_IDLE = 3'b001,
    AB_WAIT = 3'b010,
    AB_GO   = 3'b100
  } abort_state_type;

  typedef struct packed {
    logic plc_axes_hold_n;
    logic plc_block_transfer_inhibit_n;
    logic plc_aux_done;
    logic plc_block_abort;
    logic cycle_go;
    logic general_feed_hold_n;
    logic stop_n;
    logic start_key;
    logic stop_key;
    logic selftest_pass;
    logic hw_fault;
  } pin_in_type;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } avs_req_type;
endpackage

// File: hw/cnc_plc_signal_interface.sv
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// [RULE1] a set bit in any of five key masks disables that panel key
// [RULE2] selector mask bits 0-7 handwheel/jog, 8-22 override positions, rest unused
// [RULE3] fifth mask disables conversational-model keys bit by bit
// [RULE4] disabled override position falls back to nearest enabled position below
// [RULE5] with no enabled position at or below, apply zero percent
// [RULE6] axes-hold low halts plc axes, spindle keeps turning; high resumes
// [RULE7] transfer-inhibit low finishes current block, blocks next; high continues
// [RULE8] plc always drives axes-hold and transfer-inhibit
// [RULE9] after codes are loaded raise aux strobe to request execution
// [RULE10] plc drops aux-done when it sees the strobe
// [RULE11] plc runs the seven code registers, then raises aux-done
// [RULE12] accept aux-done only after it stays high longer than hold time
// [RULE13] after hold time elapses with aux-done high, drop the strobe
// [RULE14] abort ends motion, runs pending post-block aux, then starts next block
// [RULE15] abort request clears itself when acted on or refused
// [RULE16] abort honoured only in automatic and simulation with motion
// [RULE17] abort only stops moves and dwells, never when tangential control active
// [RULE18] after abort move only next block programmed axes to prepared target
// [RULE19] ready high after passed selftest, low on any hardware fault
// [RULE20] start key press raises start request
// [RULE21] cycle-go rising edge clears start request and starts program
// [RULE22] feed-held set by stop key, feed-hold low, or a stop pulse
// [RULE23] inputs sampled on system clock, edges against previous sample
module cnc_plc_signal_interface #(
  parameter int unsigned NUM_AXES = 8
) (
  input  wire logic                               clk_sys_i,
  input  wire logic                               rst_i,
  input  wire cnc_plc_pkg::avs_req_type           avs_req_i,
  output logic [31:0]                             avs_readdata_o,
  output logic                                    avs_waitrequest_o,
  input  wire cnc_plc_pkg::pin_in_type            pins_i,
  input  wire logic [cnc_plc_pkg::NUM_MASKS-1:0][31:0] keys_raw_i,
  input  wire logic [3:0]                         override_sel_i,
  input  wire logic                               aux_request_i,
  input  wire logic                               aux_post_pending_i,
  input  wire logic                               block_active_i,
  input  wire cnc_plc_pkg::block_kind_type        block_kind_i,
  input  wire logic                               tangential_active_i,
  input  wire logic                               mode_auto_i,
  input  wire logic                               mode_sim_motion_i,
  input  wire logic [NUM_AXES-1:0]                next_axes_i,
  output logic [cnc_plc_pkg::NUM_MASKS-1:0][31:0] keys_enabled_o,
  output logic [3:0]                              override_applied_o,
  output logic                                    plc_axes_halt_o,
  output logic                                    block_start_inhibit_o,
  output logic                                    plc_aux_strobe_o,
  output logic                                    motion_abort_o,
  output logic                                    next_block_go_o,
  output logic [NUM_AXES-1:0]                     abort_axes_o,
  output logic                                    selftest_ok_o,
  output logic                                    start_request_o,
  output logic                                    program_start_o,
  output logic                                    feed_held_status_o
);
  import cnc_plc_pkg::*;

  // =========================================================
  // input synchronisers
  pin_in_type                        pin_meta_q;
  pin_in_type                        pin_q;
  pin_in_type                        pin_prev_q;
  logic [NUM_MASKS-1:0][31:0]        key_meta_q;
  logic [NUM_MASKS-1:0][31:0]        key_q;
  logic [3:0]                        sel_meta_q;
  logic [3:0]                        sel_q;

  always_ff @(posedge clk_sys_i) begin
    pin_meta_q <= pins_i;
    pin_q      <= pin_meta_q; // RULE23
    pin_prev_q <= pin_q;
    key_meta_q <= keys_raw_i;
    key_q      <= key_meta_q;
    sel_meta_q <= override_sel_i;
    sel_q      <= sel_meta_q;
  end
  logic go_rise;
  logic abort_rise;
  logic start_rise;
  logic stop_fall;
  assign go_rise    = pin_q.cycle_go & ~pin_prev_q.cycle_go; // RULE23
  assign abort_rise = pin_q.plc_block_abort & ~pin_prev_q.plc_block_abort;
  assign start_rise = pin_q.start_key & ~pin_prev_q.start_key;
  assign stop_fall  = ~pin_q.stop_n & pin_prev_q.stop_n;

  // =========================================================
  // avalon slave, one wait cycle per access
  logic [NUM_MASKS-1:0][31:0] mask_q;
  logic [15:0]                ack_hold_q;
  logic [31:0]                status;
  logic [31:0]                rd_d;
  logic [9:0]                 idx;
  logic                       lanes_ok;
  logic                       abort_pend_q;

  assign idx      = avs_req_i.address[ADDR_W-1:2];
  assign lanes_ok = (avs_req_i.address[1:0] == BYTE_LANE_BITS);
  function automatic int mask_slot(input logic [9:0] i);
    unique case (i)
      IDX_KEY_INHIBIT_A:    mask_slot = 0;
      IDX_KEY_INHIBIT_B:    mask_slot = 1;
      IDX_KEY_INHIBIT_C:    mask_slot = 2;
      IDX_SELECTOR_INHIBIT: mask_slot = 3;
      IDX_CONV_KEY_INHIBIT: mask_slot = 4;
      default:              mask_slot = -1;
    endcase
  endfunction
  always_comb begin
    status                = 32'h0000_0000;
    status[ST_STROBE]     = plc_aux_strobe_o;
    status[ST_READY]      = selftest_ok_o;
    status[ST_START_REQ]  = start_request_o;
    status[ST_FEED_HELD]  = feed_held_status_o;
    status[ST_ABORT_PEND] = abort_pend_q;
  end

  always_comb begin
    rd_d = UNMAPPED_READ;
    if (lanes_ok) begin
      if (mask_slot(idx) >= 0) begin
        rd_d = mask_q[mask_slot(idx)];
      end else if (idx == IDX_ACK_HOLD) begin
        rd_d = {16'h0000, ack_hold_q};
      end else if (idx == IDX_STATUS) begin
        rd_d = status;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      // drop waitrequest for exactly one cycle per request
      avs_waitrequest_o <= ~((avs_req_i.read | avs_req_i.write) & avs_waitrequest_o);
      if (avs_req_i.read && avs_waitrequest_o) begin
        avs_readdata_o <= rd_d;
      end
    end
  end
  logic wr_take;
  assign wr_take = avs_req_i.write & ~avs_waitrequest_o & lanes_ok;

  // =========================================================
  // mask and hold-time registers
  generate
    for (genvar m = 0; m < NUM_MASKS; m++) begin : g_mask
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          mask_q[m] <= MASK_RESET;
        end else if (wr_take && mask_slot(idx) == m) begin
          for (int b = 0; b < 4; b++) begin
            if (avs_req_i.byteenable[b]) begin
              mask_q[m][b*8 +: 8] <= avs_req_i.writedata[b*8 +: 8];
            end
          end
        end
      end

      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          keys_enabled_o[m] <= 32'h0000_0000;
        end else begin
          keys_enabled_o[m] <= key_q[m] & ~mask_q[m]; // RULE1 RULE2 RULE3
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack_hold_q <= ACK_HOLD_RESET;
    end else if (wr_take && idx == IDX_ACK_HOLD) begin
      if (avs_req_i.byteenable[0]) ack_hold_q[7:0]  <= avs_req_i.writedata[7:0];
      if (avs_req_i.byteenable[1]) ack_hold_q[15:8] <= avs_req_i.writedata[15:8];
    end
  end

  // =========================================================
  // override fallback
  logic [3:0] ovr_d;
  always_comb begin
    ovr_d = OVR_LOWEST; // RULE5
    for (int p = 0; p < OVR_POSITIONS; p++) begin
      if (4'(p) <= sel_q && !mask_q[SEL_MASK][OVR_FIRST_BIT + p]) begin
        ovr_d = 4'(p); // RULE4
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      override_applied_o <= OVR_LOWEST;
    end else begin
      override_applied_o <= ovr_d; // RULE4
    end
  end

  // =========================================================
  // plc channel hold and transfer inhibit
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      plc_axes_halt_o       <= 1'b0;
      block_start_inhibit_o <= 1'b0;
    end else begin
      plc_axes_halt_o       <= ~pin_q.plc_axes_hold_n; // RULE6
      block_start_inhibit_o <= ~pin_q.plc_block_transfer_inhibit_n; // RULE7
    end
  end

  // =========================================================
  // auxiliary handshake
  // the strobe waits for done to go low first, so a stale high done
  // left over from the previous function is never taken as completion
  aux_state_type aux_q;
  logic [15:0]   hold_cnt_q;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      aux_q            <= AUX_IDLE;
      plc_aux_strobe_o <= 1'b0;
      hold_cnt_q       <= 16'h0000;
    end else begin
      unique case (aux_q)
        AUX_IDLE: begin
          hold_cnt_q <= 16'h0000;
          if (aux_request_i) begin
            aux_q            <= AUX_LOW;
            plc_aux_strobe_o <= 1'b1; // RULE9
          end
        end
        AUX_LOW: begin
          if (!pin_q.plc_aux_done) aux_q <= AUX_HIGH; // RULE10
        end
        AUX_HIGH: begin
          if (!pin_q.plc_aux_done) begin
            hold_cnt_q <= 16'h0000; // RULE12
          end else if (hold_cnt_q > ack_hold_q) begin
            aux_q            <= AUX_IDLE;
            plc_aux_strobe_o <= 1'b0; // RULE13
          end else begin
            hold_cnt_q <= hold_cnt_q + 16'h0001; // RULE12
          end
        end
      endcase
    end
  end

  // =========================================================
  // block abort
  abort_state_type ab_q;
  logic            ab_ok;
  assign ab_ok = (mode_auto_i | mode_sim_motion_i) & block_active_i // RULE16
               & (block_kind_i == BK_MOTION | block_kind_i == BK_DWELL) // RULE17
               & ~tangential_active_i; // RULE17

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      abort_pend_q <= 1'b0;
    end else if (abort_rise) begin
      abort_pend_q <= 1'b1;
    end else if (ab_q == AB_IDLE) begin
      abort_pend_q <= 1'b0; // RULE15
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ab_q            <= AB_IDLE;
      motion_abort_o  <= 1'b0;
      next_block_go_o <= 1'b0;
      abort_axes_o    <= '0;
    end else begin
      motion_abort_o  <= 1'b0;
      next_block_go_o <= 1'b0;
      unique case (ab_q)
        AB_IDLE: begin
          if (abort_pend_q && ab_ok) begin
            ab_q           <= AB_WAIT;
            motion_abort_o <= 1'b1; // RULE14
            abort_axes_o   <= next_axes_i; // RULE18
          end
        end
        AB_WAIT: begin
          // post-block functions run to completion before the next block
          if (!aux_post_pending_i && aux_q == AUX_IDLE && !aux_request_i) begin
            ab_q <= AB_GO; // RULE14
          end
        end
        AB_GO: begin
          ab_q            <= AB_IDLE;
          next_block_go_o <= 1'b1; // RULE14
        end
      endcase
    end
  end

  // =========================================================
  // ready, start and feed-held outputs
  // a fault latches ready low until reset; a later pass cannot mask it
  logic fault_seen_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fault_seen_q  <= 1'b0;
      selftest_ok_o <= 1'b0;
    end else begin
      if (pin_q.hw_fault) fault_seen_q <= 1'b1;
      selftest_ok_o <= pin_q.selftest_pass & ~pin_q.hw_fault & ~fault_seen_q; // RULE19
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      start_request_o <= 1'b0;
      program_start_o <= 1'b0;
    end else begin
      program_start_o <= go_rise; // RULE21
      if (start_rise) begin
        start_request_o <= 1'b1; // RULE20
      end else if (go_rise) begin
        start_request_o <= 1'b0; // RULE21
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      feed_held_status_o <= 1'b0;
    end else if (pin_q.stop_key || !pin_q.general_feed_hold_n || stop_fall) begin
      feed_held_status_o <= 1'b1; // RULE22
    end else if (go_rise) begin
      feed_held_status_o <= 1'b0;
    end
  end

  // =========================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_key_gate;
    key_q[0][0] && mask_q[0][0] |=> !keys_enabled_o[0][0];
  endproperty
  a_key_gate: assert property (p_key_gate) else $error("masked key passed"); // RULE1
  property p_ovr_zero;
    (&mask_q[SEL_MASK][OVR_FIRST_BIT +: OVR_POSITIONS]) |=> override_applied_o == OVR_LOWEST;
  endproperty
  a_ovr_zero: assert property (p_ovr_zero) else $error("override not zero"); // RULE5
  property p_ovr_below;
    1'b1 |=> override_applied_o <= $past(sel_q);
  endproperty
  a_ovr_below: assert property (p_ovr_below) else $error("override above selection"); // RULE4
  property p_halt;
    !pin_q.plc_axes_hold_n |=> plc_axes_halt_o;
  endproperty
  a_halt: assert property (p_halt) else $error("axes not halted"); // RULE6
  property p_xfer;
    $fell(pin_q.plc_block_transfer_inhibit_n) |=> block_start_inhibit_o;
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer not inhibited"); // RULE7
  property p_strobe_up;
    aux_q == AUX_IDLE && aux_request_i |=> plc_aux_strobe_o;
  endproperty
  a_strobe_up: assert property (p_strobe_up) else $error("strobe not raised"); // RULE9
  property p_strobe_hold;
    aux_q == AUX_HIGH && !pin_q.plc_aux_done |=> plc_aux_strobe_o[*2];
  endproperty
  a_strobe_hold: assert property (p_strobe_hold) else $error("strobe dropped early"); // RULE12
  property p_strobe_down;
    $fell(plc_aux_strobe_o) |-> $past(hold_cnt_q) > ack_hold_q && $past(pin_q.plc_aux_done);
  endproperty
  a_strobe_down: assert property (p_strobe_down) else $error("strobe fell early"); // RULE13
  property p_abort_gate;
    motion_abort_o |-> $past(ab_ok) && $past(abort_pend_q);
  endproperty
  a_abort_gate: assert property (p_abort_gate) else $error("abort out of mode"); // RULE16
  property p_abort_clear;
    abort_pend_q && !ab_ok && ab_q == AB_IDLE && !abort_rise |=> !abort_pend_q;
  endproperty
  a_abort_clear: assert property (p_abort_clear) else $error("abort carried over"); // RULE15
  property p_start;
    go_rise && !start_rise |=> !start_request_o ##0 program_start_o;
  endproperty
  a_start: assert property (p_start) else $error("start not cleared"); // RULE21
  property p_fault;
    pin_q.hw_fault |=> !selftest_ok_o;
  endproperty
  a_fault: assert property (p_fault) else $error("ready during fault"); // RULE19
  property p_feed_held;
    stop_fall |=> feed_held_status_o;
  endproperty
  a_feed_held: assert property (p_feed_held) else $error("feed held missed"); // RULE22
  c_aux_done: cover property ($fell(plc_aux_strobe_o));
  c_abort: cover property (motion_abort_o ##[1:50] next_block_go_o);
  c_ovr_fallback: cover property (override_applied_o != sel_q && override_applied_o != OVR_LOWEST);
  c_start: cover property (start_request_o ##[1:20] program_start_o);
endmodule

// File: verification/cnc_plc_signal_interface_tb_top.sv
`timescale 1ns/1ps
module cnc_plc_signal_interface_tb_top;
  import cnc_plc_pkg::*;
  typedef struct { int idx; logic [31:0] exp; } note_type;
  logic clk_sys_i = 1'b0, rst_i = 1'b1;
  avs_req_type req = '0;
  logic [31:0] avs_readdata_o, m [5], obs [16];
  logic avs_waitrequest_o, done, go, hold_n, xfer_n, halt, binh, strobe, mab, nbg, ready, sreq;
  logic pst, fheld, stop_n = 1, start_key = 0, stop_key = 0, st_pass = 0, hw_fault = 0;
  logic abort_in = 0, gfh_n = 1, aux_req = 0, post = 0, blk = 0, tang = 0, m_auto = 0;
  logic m_sim = 0, grant = 0, hold = 0, inh = 0;
  logic [3:0] dly = 0, sel = 0, ovr;
  logic [7:0] axes = 0, ab_axes;
  block_kind_type kind = BK_MOTION;
  logic [NUM_MASKS-1:0][31:0] keys = '0, ken;
  logic [11:0] ma [5] = '{12'h7D0, 12'h7D4, 12'h7D8, 12'h7DC, 12'h7F0};
  string nm [16] = '{"keys0", "keys1", "keys2", "keys3", "keys4", "override", "halt",
    "inhibit", "strobe", "abort_axes", "ready", "start_req", "feed_held", "aborts",
    "next_go", "prog_start"};
  note_type rd_q [$], pr_q [$];
  int err_total = 0, num_checks = 0, cyc = 0, n_ab = 0, n_go = 0, n_ps = 0;
  int e_ab = 0, e_go = 0;
  initial forever #20 clk_sys_i = !clk_sys_i;
  plc_model plc (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .strobe_i(strobe),
    .start_request_i(sreq), .delay_i(dly), .grant_i(grant), .hold_i(hold),
    .inhibit_i(inh), .aux_done_o(done), .cycle_go_o(go), .axes_hold_n_o(hold_n),
    .xfer_inhibit_n_o(xfer_n));
  cnc_plc_signal_interface DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_req_i(req),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .pins_i({hold_n, xfer_n, done, abort_in, go, gfh_n, stop_n, start_key, stop_key,
      st_pass, hw_fault}),
    .keys_raw_i(keys), .override_sel_i(sel), .aux_request_i(aux_req),
    .aux_post_pending_i(post), .block_active_i(blk), .block_kind_i(kind),
    .tangential_active_i(tang), .mode_auto_i(m_auto), .mode_sim_motion_i(m_sim),
    .next_axes_i(axes), .keys_enabled_o(ken), .override_applied_o(ovr),
    .plc_axes_halt_o(halt), .block_start_inhibit_o(binh), .plc_aux_strobe_o(strobe),
    .motion_abort_o(mab), .next_block_go_o(nbg), .abort_axes_o(ab_axes),
    .selftest_ok_o(ready), .start_request_o(sreq), .program_start_o(pst),
    .feed_held_status_o(fheld));
  always_comb begin
    for (int i = 0; i < 5; i++) obs[i] = ken[i];
    obs[5] = 32'(ovr);
    obs[6] = 32'(halt);
    obs[7] = 32'(binh);
    obs[8] = 32'(strobe);
    obs[9] = 32'(ab_axes);
    obs[10] = 32'(ready);
    obs[11] = 32'(sreq);
    obs[12] = 32'(fheld);
    obs[13] = n_ab;
    obs[14] = n_go;
    obs[15] = n_ps;
  end
  // =========================================================
  // monitor: pulse counters, read results, settled port values
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
    cmp("readdata", e, g);
  endtask
  always @(posedge clk_sys_i) begin
    n_ab += (mab === 1'b1);
    n_go += (nbg === 1'b1);
    n_ps += (pst === 1'b1);
    if (req.read && avs_waitrequest_o === 1'b0) begin
      automatic note_type t = rd_q.pop_front();
      cmp_rd(t.exp, avs_readdata_o);
    end
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  always @(negedge clk_sys_i) while (pr_q.size() > 0) begin
    automatic note_type t = pr_q.pop_front();
    cmp(nm[t.idx], t.exp, obs[t.idx]);
  end
  // =========================================================
  // driver tasks
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    req <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: 4'hF};
    do begin
      @(posedge clk_sys_i);
    end while (avs_waitrequest_o !== 1'b0);
    req <= '0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back('{0, e});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic probe(input int i, input logic [31:0] e);
    pr_q.push_back('{i, e});
  endtask
  task automatic until_(input int i, input logic [31:0] v);
    for (int n = 0; n < 40 && obs[i] !== v; n++) @(posedge clk_sys_i);
  endtask
  function automatic logic [3:0] fb(input logic [31:0] mk, input logic [3:0] s);
    for (int p = 14; p >= 0; p--) if (p <= s && !mk[OVR_FIRST_BIT+p]) return 4'(p);
    return OVR_LOWEST;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // =========================================================
  // main sequence
  block_kind_type kt [7] = '{BK_MOTIONLESS, BK_THREAD, BK_TAP, BK_SPINDLE, BK_MOTION,
    BK_MOTION, BK_DWELL};
  logic [6:0] kta = 7'b0011111, kts = 7'b1000000, ktt = 7'b0010000, kok = 7'b1000000;
  initial begin
    void'($urandom(83226));
    w(20);
    rst_i <= 1'b0;
    w(6);
    probe(10, 0);
    for (int i = 0; i < 5; i++) rd(ma[i], MASK_RESET);
    rd(12'h7E0, UNMAPPED_READ);
    rd(12'h800, 32'(ACK_HOLD_RESET));
    st_pass <= 1'b1;
    for (int r = 0; r < 6; r++) begin
      for (int i = 0; i < 5; i++) begin
        m[i] = (r == 0) ? 32'hFFFF_FFFF : $urandom();
        bus(1'b1, ma[i], m[i]);
        rd(ma[i], m[i]);
      end
      for (int i = 0; i < 5; i++) keys[i] <= $urandom();
      sel <= 4'($urandom() % 15);
      w(6);
      for (int i = 0; i < 5; i++) probe(i, keys[i] & ~m[i]);
      probe(5, 32'(fb(m[3], sel)));
    end
    probe(10, 1);
    hold <= 1'b1;
    inh <= 1'b1;
    w(6);
    probe(6, 1);
    probe(7, 1);
    hold <= 1'b0;
    inh <= 1'b0;
    w(6);
    probe(6, 0);
    probe(7, 0);
    bus(1'b1, 12'h800, 32'h2);
    for (int j = 0; j < 2; j++) begin
      dly <= (j == 0) ? 4'h1 : 4'h9;
      aux_req <= 1'b1;
      @(posedge clk_sys_i);
      aux_req <= 1'b0;
      w(2);
      probe(8, 1);
      while (done !== 1'b0) @(posedge clk_sys_i);
      while (done !== 1'b1) @(posedge clk_sys_i);
      w(3);
      probe(8, 1);
      until_(8, 0);
      probe(8, 0);
    end
    // abort with post-block aux still owed: next block waits for it
    m_auto <= 1'b1;
    blk <= 1'b1;
    post <= 1'b1;
    axes <= 8'($urandom());
    abort_in <= 1'b1;
    w(8);
    abort_in <= 1'b0;
    e_ab++;
    probe(13, e_ab);
    probe(9, 32'(axes));
    probe(14, e_go);
    post <= 1'b0;
    w(6);
    e_go++;
    probe(14, e_go);
    for (int i = 0; i < 7; i++) begin
      kind <= kt[i];
      m_auto <= kta[i];
      m_sim <= kts[i];
      tang <= ktt[i];
      abort_in <= 1'b1;
      w(8);
      abort_in <= 1'b0;
      w(6);
      e_ab += kok[i];
      probe(13, e_ab);
    end
    stop_n <= 1'b0;
    w(2);
    stop_n <= 1'b1;
    w(6);
    probe(12, 1);
    start_key <= 1'b1;
    w(6);
    probe(11, 1);
    start_key <= 1'b0;
    grant <= 1'b1;
    w(8);
    probe(11, 0);
    probe(15, 1);
    probe(12, 0);
    grant <= 1'b0;
    gfh_n <= 1'b0;
    w(6);
    probe(12, 1);
    gfh_n <= 1'b1;
    hw_fault <= 1'b1;
    w(6);
    probe(10, 0);
    hw_fault <= 1'b0;
    w(6);
    probe(10, 0);
    rd(12'h804, 32'h1 << ST_FEED_HELD);
    w(2);
    report_and_stop();
  end
endmodule

// File: verification/plc_model.sv
`timescale 1ns/1ps
// =========================================================
// plc program model: aux handshake, start grant, channel holds
module plc_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       strobe_i,
  input  wire logic       start_request_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       grant_i,
  input  wire logic       hold_i,
  input  wire logic       inhibit_i,
  output logic            aux_done_o,
  output logic            cycle_go_o,
  output logic            axes_hold_n_o,
  output logic            xfer_inhibit_n_o
);
  logic [3:0] cnt_q;
  logic       busy_q;
  // done starts high so the first strobe shows a real fall then rise
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      aux_done_o <= 1'b1;
      busy_q     <= 1'b0;
      cnt_q      <= 4'h0;
    end else if (strobe_i && !busy_q) begin
      aux_done_o <= 1'b0;
      busy_q     <= 1'b1;
      cnt_q      <= delay_i;
    end else if (busy_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (busy_q && strobe_i) begin
      aux_done_o <= 1'b1;
    end else begin
      busy_q <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    cycle_go_o       <= !rst_i && grant_i && start_request_i;
    axes_hold_n_o    <= rst_i || !hold_i;
    xfer_inhibit_n_o <= rst_i || !inhibit_i;
  end
endmodule
